// ### src/qdu_update_ctrl.sv
`timescale 1ns/1ps
// How it works
// RL1: Strobe high on write: input only, fall loads.
// RL2: Mask command loads four low data bits.
// RL3: Mask bit n governs channel n, A lowest.
// RL4: Reset clears every mask bit.
// RL5: Masked channel sees strobe as always high; here only its fall is ignored.
// RL6: Strobe falling edge loads unmasked DAC registers.
// RL7: Strobe held low ignores mask bits.
// RL8: Write-input updates DAC only with strobe low.
// RL9: Update command copies input to DAC register.
// RL10: Write-and-update loads both registers.
// RL11: Clear pin forces zero or midscale code.
// RL12: Clear pin low blocks updates; code persists.
// RL13: Software reset equals power-on reset.
// RL14: Strobe ignored during power-on initialisation.
// RL15: Initialisation waits for clear pin release.
// RL16: Reset level select picks zero or midscale.
// RL17: Reset code holds until first valid write.
// RL18: Strobe low write updates both on word end.
// RL19: Word is 24 bits, code in top four.
// RL20: Pins pass two flops; edge found in core.
module qdu_update_ctrl
   import qdu_pkg::*;
#(
   parameter int DATA_W = 16
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_link_clk,
   input wire logic i_link_reset,
   input wire logic i_link_valid,
   input wire logic [WORD_W-1:0] i_link_word,
   output logic o_link_ready,
   input wire logic i_load_dac_strobe_n,
   input wire logic i_clear_n,
   input wire logic i_reset_level_select,
   output logic [NUM_CH-1:0][DATA_W-1:0] o_dac_code,
   output logic [NUM_CH-1:0][DATA_W-1:0] o_input_code,
   output logic [NUM_CH-1:0] o_strobe_mask,
   output logic o_init_done
);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   // The data field holds sixteen bits; narrower codes use its top.
   if (DATA_W < 1 || DATA_W > DATA_HI + 1) begin : g_bad_width
      $error("qdu_update_ctrl: DATA_W must be 1 to 16");
   end

   // ****************************************************************
   // Link side and word crossing
   // ****************************************************************
   qdu_xfer_if xfer ();

   // Words arrive on the link clock and wait there for the core.
   qdu_link_rx u_link_rx (
      .i_link_clk(i_link_clk),
      .i_link_reset(i_link_reset),
      .i_valid(i_link_valid),
      .i_word(i_link_word),
      .o_ready(o_link_ready),
      .xfer(xfer.link)
   );

   logic req_s1_r;   // First stage of the request toggle.
   logic req_s2_r;   // Second stage of the request toggle.
   logic ack_r;      // Acknowledge toggle back to the link.

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic load_dac_strobe_s1_r;  // Strobe pin, first stage.
   logic load_dac_strobe_s2_r;  // Strobe pin, second stage.
   logic load_dac_strobe_prv_r; // Strobe level one cycle earlier.
   logic clr_s1_r;   // Clear pin, first stage.
   logic clr_s2_r;   // Clear pin, second stage.
   logic sel_s1_r;   // Reset level select, first stage.
   logic sel_s2_r;   // Reset level select, second stage.

   // All three pins are asynchronous to the core clock. Reset values
   // are chosen so that no false strobe edge and no early release
   // of the clear pin is seen after reset.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         load_dac_strobe_s1_r <= 1'b1;
         load_dac_strobe_s2_r <= 1'b1;
         clr_s1_r <= 1'b0;
         clr_s2_r <= 1'b0;
         sel_s1_r <= 1'b0;
         sel_s2_r <= 1'b0;
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
      end else if (i_ce) begin
         load_dac_strobe_s1_r <= i_load_dac_strobe_n; // RL20
         load_dac_strobe_s2_r <= load_dac_strobe_s1_r;
         clr_s1_r <= i_clear_n; // RL20
         clr_s2_r <= clr_s1_r;
         sel_s1_r <= i_reset_level_select;
         sel_s2_r <= sel_s1_r;
         req_s1_r <= xfer.req_tgl;
         req_s2_r <= req_s1_r;
      end
   end

   // ****************************************************************
   // Control state
   // ****************************************************************
   qdu_state_t st_r;                 // Initialising or running.
   logic [NUM_CH-1:0] mask_r;        // Strobe mask, bit n = channel n.
   logic [3:0] clr_cnt_r;            // Cycles the clear pin was low.
   logic [DATA_W-1:0] in_r [NUM_CH]; // Input registers.
   logic [DATA_W-1:0] dac_r [NUM_CH];// DAC registers.

   // ****************************************************************
   // Decoding
   // ****************************************************************
   wire pending = req_s2_r ^ ack_r;          // A word waits.
   wire take = i_ce && pending;               // Word consumed.
   wire clr_act = (clr_cnt_r >= 4'(CLR_MIN_CYC)); // RL11
   wire hold = (st_r == QDU_INIT) || clr_act; // Outputs forced to reset code.
   // Words that arrive while outputs are held are dropped.
   wire act = take && !hold; // RL12
   wire [WORD_W-1:0] w = xfer.word;
   wire [NUM_CH-1:0] addr = w[ADDR_HI:ADDR_LO]; // RL19
   wire [DATA_W-1:0] dat = w[DATA_HI -: DATA_W]; // RL19
   wire [NUM_CH-1:0] mask_dat = w[MASK_HI:0];
   wire cmd_wr_in = act && qdu_is_cmd(w, CMD_WR_IN); // RL19
   wire cmd_upd = act && qdu_is_cmd(w, CMD_UPD);
   wire cmd_wr_upd = act && qdu_is_cmd(w, CMD_WR_UPD);
   wire cmd_mask = act && qdu_is_cmd(w, CMD_MASK);
   wire cmd_swrst = act && qdu_is_cmd(w, CMD_SWRST);
   // Falling edge of the strobe, seen only after both stages.
   wire fall = load_dac_strobe_prv_r && !load_dac_strobe_s2_r; // RL20
   wire edge_ok = fall && !hold; // RL14
   // Zero scale or midscale, chosen by the select pin.
   wire [DATA_W-1:0] mid_code = {1'b1, {(DATA_W-1){1'b0}}};
   wire [DATA_W-1:0] rst_code = sel_s2_r ? mid_code : '0; // RL16

   // Acknowledge every taken word and keep the strobe history.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ack_r <= 1'b0;
         load_dac_strobe_prv_r <= 1'b1;
      end else if (i_ce) begin
         ack_r <= ack_r ^ take;
         load_dac_strobe_prv_r <= load_dac_strobe_s2_r;
      end
   end
   assign xfer.ack_tgl = ack_r;

   // Count how long the clear pin has been low; a short glitch that
   // misses both synchroniser stages is not seen at all, which is a
   // limitation of sampling a 30 ns pulse with a slow clock.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         clr_cnt_r <= '0;
      end else if (i_ce) begin
         if (clr_s2_r) begin
            clr_cnt_r <= '0;
         end else if (!clr_act) begin
            clr_cnt_r <= clr_cnt_r + 4'h1;
         end
      end
   end

   // Initialisation lasts until the clear pin is released; the
   // software reset command re-enters it like power-on.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_r <= QDU_INIT;
      end else if (i_ce) begin
         case (st_r)
            QDU_INIT: begin
               if (clr_s2_r) begin // RL15
                  st_r <= QDU_RUN;
               end
            end
            QDU_RUN: begin
               if (cmd_swrst) begin // RL13
                  st_r <= QDU_INIT;
               end
            end
            default: begin
               st_r <= QDU_INIT;
            end
         endcase
      end
   end

   // The mask command ignores the channel select field.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mask_r <= MASK_RST; // RL4
      end else if (i_ce) begin
         if (st_r == QDU_INIT) begin
            mask_r <= MASK_RST; // RL4
         end else if (cmd_mask) begin
            mask_r <= mask_dat; // RL2 RL3
         end
      end
   end

   // ****************************************************************
   // Per-channel registers
   // ****************************************************************
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      wire sel = addr[i];
      wire ld_in = (cmd_wr_in || cmd_wr_upd) && sel; // RL8 RL10
      // Strobe low during write-input updates at once, mask or not.
      wire ld_dat = sel && (cmd_wr_upd || (cmd_wr_in && !load_dac_strobe_s2_r));
      // Masked channels skip the strobe edge but not its low level.
      wire ld_cpy = (cmd_upd && sel) || (edge_ok && !mask_r[i]);

      // Hold forces the reset code; a command write to a channel
      // wins over a strobe copy in the same cycle.
      always_ff @(posedge i_clk) begin
         if (i_reset) begin
            in_r[i] <= '0;
            dac_r[i] <= '0;
         end else if (i_ce) begin
            if (hold) begin
               in_r[i] <= rst_code; // RL11 RL17
               dac_r[i] <= rst_code; // RL12 RL16 RL17
            end else begin
               if (ld_in) begin
                  in_r[i] <= dat; // RL1 RL8
               end
               if (ld_dat) begin
                  dac_r[i] <= dat; // RL7 RL10 RL18
               end else if (ld_cpy) begin
                  dac_r[i] <= in_r[i]; // RL1 RL5 RL6 RL9
               end
            end
         end
      end
      assign o_dac_code[i] = dac_r[i];
      assign o_input_code[i] = in_r[i];
   end

   assign o_strobe_mask = mask_r;
   assign o_init_done = (st_r == QDU_RUN);

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   wire c0 = addr[0];

   mask_load_a: assert property (cmd_mask |=> // RL2
      mask_r == $past(mask_dat))
      else $error("mask not loaded from low data bits");
   mask_reset_a: assert property (i_ce && st_r == QDU_INIT |=> // RL4
      mask_r == MASK_RST)
      else $error("mask not cleared during init");
   masked_hold_a: assert property ( // RL5
      i_ce && edge_ok && mask_r[0] && !act |=> $stable(dac_r[0]))
      else $error("masked channel followed strobe edge");
   edge_copy_a: assert property ( // RL6
      i_ce && edge_ok && !mask_r[0] && !act
      |=> dac_r[0] == $past(in_r[0]))
      else $error("strobe edge did not copy input");
   wr_high_a: assert property ( // RL8
      cmd_wr_in && c0 && load_dac_strobe_s2_r
      |=> in_r[0] == $past(dat) && $stable(dac_r[0]))
      else $error("write with strobe high misbehaved");
   wr_low_a: assert property (cmd_wr_in && c0 && !load_dac_strobe_s2_r // RL18
      |=> dac_r[0] == $past(dat) && in_r[0] == $past(dat))
      else $error("write with strobe low missed DAC");
   update_cmd_a: assert property (cmd_upd && c0 // RL9
      |=> dac_r[0] == $past(in_r[0]) && $stable(in_r[0]))
      else $error("update command wrong");
   wr_update_a: assert property (cmd_wr_upd && c0 // RL10
      |=> dac_r[0] == $past(dat) && in_r[0] == $past(dat))
      else $error("write and update wrong");
   clear_hold_a: assert property (i_ce && clr_act // RL12
      |=> dac_r[0] == $past(rst_code))
      else $error("clear did not force reset code");
   swrst_init_a: assert property (cmd_swrst // RL13
      |=> st_r == QDU_INIT)
      else $error("software reset not taken");
   init_wait_a: assert property ( // RL15
      st_r == QDU_INIT && !clr_s2_r |=> st_r == QDU_INIT)
      else $error("init left with clear pin low");

   edge_cov: cover property (edge_ok && !mask_r[0] ##1 1'b1);
   mask_cov: cover property (cmd_mask);
   swrst_cov: cover property (cmd_swrst ##1 st_r == QDU_INIT);
   clear_cov: cover property (clr_act ##1 !clr_act);

endmodule

// ### src/qdu_pkg.sv
package qdu_pkg;

   // ****************************************************************
   // Command word layout
   // ****************************************************************
   localparam int NUM_CH = 4;     // Channels A to D.
   localparam int WORD_W = 24;    // Bits in one command word.
   localparam int CMD_HI = 23;    // Top bit of the command code.
   localparam int CMD_LO = 20;    // Bottom bit of the command code.
   localparam int ADDR_HI = 19;   // Top bit of the channel select.
   localparam int ADDR_LO = 16;   // Bottom bit of the channel select.
   localparam int DATA_HI = 15;   // Top bit of the data field.
   localparam int MASK_HI = 3;    // Top bit of the mask data field.

   // ****************************************************************
   // Command codes and reset values
   // ****************************************************************
   localparam logic [3:0] CMD_WR_IN = 4'h1;   // Write input register.
   localparam logic [3:0] CMD_UPD = 4'h2;     // Copy input to output.
   localparam logic [3:0] CMD_WR_UPD = 4'h3;  // Write both registers.
   localparam logic [3:0] CMD_MASK = 4'h5;    // Load strobe mask.
   localparam logic [3:0] CMD_SWRST = 4'h6;   // Software reset.
   localparam logic [3:0] MASK_RST = 4'h0;    // Mask value after reset.

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 100;  // Core clock period.
   localparam int CLR_MIN_NS = 30;      // Least low time of clear pin.
   // Least time rounds up to whole cycles, never below one.
   localparam int CLR_MIN_RAW =
      (CLR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLR_MIN_CYC = (CLR_MIN_RAW < 1) ? 1 : CLR_MIN_RAW;

   // Core control states.
   typedef enum {QDU_INIT, QDU_RUN} qdu_state_t;

   // True when a command word carries the given code.
   function automatic logic qdu_is_cmd(input logic [WORD_W-1:0] w,
                                       input logic [3:0] code);
      return w[CMD_HI:CMD_LO] == code;
   endfunction

endpackage

// ### src/qdu_xfer_if.sv
`timescale 1ns/1ps
// Word hand-over from the link domain to the core domain.
interface qdu_xfer_if;
   import qdu_pkg::*;
   logic req_tgl;              // Toggles once per word offered.
   logic [WORD_W-1:0] word;    // Held stable until acknowledged.
   logic ack_tgl;              // Toggles once per word taken.
   modport link (output req_tgl, output word, input ack_tgl);
   modport core (input req_tgl, input word, output ack_tgl);
endinterface

// ### src/qdu_link_rx.sv
`timescale 1ns/1ps
// Link-side capture of command words, on the link clock.
module qdu_link_rx
   import qdu_pkg::*;
(
   input wire logic i_link_clk,
   input wire logic i_link_reset,
   input wire logic i_valid,
   input wire logic [WORD_W-1:0] i_word,
   output logic o_ready,
   qdu_xfer_if.link xfer
);

   // ****************************************************************
   // Handshake state
   // ****************************************************************
   logic req_r;                // Request toggle.
   logic [WORD_W-1:0] word_r;  // Word on offer to the core.
   logic ack_s1_r;             // First synchroniser stage.
   logic ack_s2_r;             // Second synchroniser stage.
   logic take;                 // A word is accepted this edge.

   // Ready only once the core has answered the last toggle, so the
   // held word never changes while the core may be sampling it.
   assign o_ready = (ack_s2_r == req_r);
   assign take = i_valid && o_ready;
   assign xfer.req_tgl = req_r;
   assign xfer.word = word_r;

   // Bring the acknowledge toggle into the link domain.
   always_ff @(posedge i_link_clk) begin
      if (i_link_reset) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         ack_s1_r <= xfer.ack_tgl;
         ack_s2_r <= ack_s1_r;
      end
   end

   // Capture an accepted word and announce it by a toggle.
   always_ff @(posedge i_link_clk) begin
      if (i_link_reset) begin
         req_r <= 1'b0;
         word_r <= '0;
      end else if (take) begin
         req_r <= ~req_r;
         word_r <= i_word;
      end
   end

endmodule

// ### sim/qdu_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host side of the word link
// ****************************************************************
// Offers one command word at a time, as the serial host would once
// all 24 bits have arrived.
module qdu_host_model
   import qdu_pkg::*;
(
   input wire logic i_link_clk,
   input wire logic i_ready,
   output logic o_valid,
   output logic [WORD_W-1:0] o_word
);
   // Idle at time zero, with no word offered.
   initial begin
      o_valid = 1'b0;
      o_word = '0;
   end

   // Offers a word after a stall, holds it until ready is seen high.
   // A released word shows its inverse, so stale data cannot pass.
   task automatic send(input logic [WORD_W-1:0] w, input int stall);
      repeat (stall) @(posedge i_link_clk);
      o_valid <= 1'b1;
      o_word <= w;
      do @(posedge i_link_clk); while (i_ready !== 1'b1);
      o_valid <= 1'b0;
      o_word <= ~w;
   endtask
endmodule

// ### sim/tb_quad_dac_update_control.sv
`timescale 1ns/1ps
module tb_quad_dac_update_control;
   import qdu_pkg::*;
   // ****************************************************************
   // Clocks, pins and reference model
   // ****************************************************************
   logic i_clk = 1'b0;
   logic i_link_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_link_reset = 1'b1;
   logic i_ce = 1'b1;
   logic strobe_n = 1'b1;    // Load strobe pin, idle high.
   logic clear_n = 1'b0;     // Clear pin held low at power-up.
   logic rsel = 1'b1;        // Start with midscale reset code.
   logic valid;
   logic [WORD_W-1:0] word;
   logic ready;
   logic [NUM_CH-1:0][15:0] dac;
   logic [NUM_CH-1:0][15:0] inp;
   logic [3:0] mask;
   logic init_done;
   int failures = 0;
   int n_tests = 0;
   int m_inp[4];             // Model input registers.
   int m_dac[4];             // Model DAC registers.
   logic [3:0] m_mask = 4'h0;
   int rcode = 'h8000;       // Code that reset and clear load.
   bit blk = 1'b1;           // Model ignores updates while set.
   logic [31:0] seed = 32'h5f;

   // Core clock at 10 MHz.
   always #50 i_clk = ~i_clk;
   // Link clock, 30 ns, with an odd phase offset to the core.
   initial begin
      #7;
      forever #15 i_link_clk = ~i_link_clk;
   end

   qdu_update_ctrl i_dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
      .i_link_clk(i_link_clk), .i_link_reset(i_link_reset),
      .i_link_valid(valid), .i_link_word(word),
      .o_link_ready(ready), .i_load_dac_strobe_n(strobe_n),
      .i_clear_n(clear_n), .i_reset_level_select(rsel),
      .o_dac_code(dac), .o_input_code(inp),
      .o_strobe_mask(mask), .o_init_done(init_done)
   );

   qdu_host_model hst (
      .i_link_clk(i_link_clk), .i_ready(ready),
      .o_valid(valid), .o_word(word)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Xorshift source, so every run sees the same values.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Counts a comparison and reports any mismatch.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Compares every register against the model.
   task automatic cmp_all();
      for (int i = 0; i < 4; i++) begin
         chk(dac[i], m_dac[i][15:0]);
         chk(inp[i], m_inp[i][15:0]);
      end
      chk(mask, m_mask);
   endtask

   // Loads the reset code into every model input and DAC register.
   task automatic set_rst();
      for (int i = 0; i < 4; i++) begin
         m_inp[i] = rcode;
         m_dac[i] = rcode;
      end
   endtask

   // Sends one word, applies it to the model, waits for the take.
   task automatic cmd(input logic [3:0] c, input logic [3:0] ch,
                      input logic [15:0] d);
      int k;
      hst.send({c, ch, d}, int'(rnd() % 3));
      for (int i = 0; i < 4; i++) begin
         if (ch[i] && !blk) begin
            case (c)
               CMD_WR_IN: begin
                  m_inp[i] = d;
                  if (!strobe_n) m_dac[i] = d;
               end
               CMD_UPD: m_dac[i] = m_inp[i];
               CMD_WR_UPD: begin
                  m_inp[i] = d;
                  m_dac[i] = d;
               end
               default: ;
            endcase
         end
      end
      if (c == CMD_MASK && !blk) m_mask = d[3:0];
      if (c == CMD_SWRST && !blk) begin
         m_mask = 4'h0;
         set_rst();
      end
      @(posedge i_link_clk);
      for (k = 0; k < 60 && ready !== 1'b1; k++) @(posedge i_link_clk);
      // A word that is never answered counts as a mismatch here.
      chk(ready, 1);
      repeat (2) @(posedge i_clk);
   endtask

   // Moves the strobe pin; a fall copies unmasked channels.
   task automatic strobe_to(input logic lvl);
      @(posedge i_clk) strobe_n <= lvl;
      repeat (4) @(posedge i_clk);
      for (int i = 0; i < 4; i++) begin
         if (!lvl && !blk && !m_mask[i]) m_dac[i] = m_inp[i];
      end
   endtask

   // Waits a bounded time for the run state.
   task automatic wait_init();
      int k;
      for (k = 0; k < 30 && init_done !== 1'b1; k++) @(posedge i_clk);
      repeat (2) @(posedge i_clk);
      chk(init_done, 1);
   endtask

   // Prints the verdict and stops the run.
   task automatic end_of_test();
      if (failures == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Cuts a hang short; the sequence needs far less than this.
   initial begin
      #3_000_000;
      failures++;
      end_of_test();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      set_rst();
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_link_clk) i_link_reset <= 1'b0;
      repeat (10) @(posedge i_clk);
      chk(init_done, 0);
      strobe_to(0);
      strobe_to(1);
      cmp_all();
      @(posedge i_clk) clear_n <= 1'b1;
      wait_init();
      blk = 1'b0;
      cmp_all();
      // Deferred load: inputs first, then one strobe pulse.
      for (int i = 0; i < 4; i++) cmd(CMD_WR_IN, 4'h1 << i, 16'(rnd()));
      cmp_all();
      strobe_to(0);
      strobe_to(1);
      cmp_all();
      // Mask channels A and C; address bits must not matter.
      cmd(CMD_MASK, 4'ha, 16'hfff5);
      cmp_all();
      for (int i = 0; i < 4; i++) cmd(CMD_WR_IN, 4'h1 << i, 16'(rnd()));
      strobe_to(0);
      strobe_to(1);
      cmp_all();
      // Strobe held low: masked channels still follow the write.
      strobe_to(0);
      cmd(CMD_WR_IN, 4'h3, 16'(rnd()));
      cmp_all();
      strobe_to(1);
      cmd(CMD_WR_IN, 4'hf, 16'(rnd()));
      cmd(CMD_UPD, 4'h5, 16'(rnd()));
      cmp_all();
      cmd(CMD_WR_UPD, 4'h8, 16'(rnd()));
      cmd(4'h4, 4'hf, 16'(rnd()));
      cmp_all();
      // Clock enable low freezes the core, so a strobe pulse that
      // starts and ends inside the frozen span is never seen.
      // Channel B still holds a pending input value here.
      blk = 1'b1;
      @(posedge i_clk) i_ce <= 1'b0;
      strobe_to(0);
      strobe_to(1);
      @(posedge i_clk) i_ce <= 1'b1;
      repeat (3) @(posedge i_clk);
      blk = 1'b0;
      cmp_all();
      // Clear pin with zero scale selected; updates are blocked.
      @(posedge i_clk) rsel <= 1'b0;
      repeat (3) @(posedge i_clk);
      @(posedge i_clk) clear_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      rcode = 0;
      set_rst();
      blk = 1'b1;
      cmd(CMD_WR_UPD, 4'hf, 16'(rnd()));
      strobe_to(0);
      strobe_to(1);
      cmp_all();
      @(posedge i_clk) clear_n <= 1'b1;
      blk = 1'b0;
      repeat (4) @(posedge i_clk);
      cmp_all();
      // Software reset back to midscale clears the mask too.
      @(posedge i_clk) rsel <= 1'b1;
      repeat (3) @(posedge i_clk);
      rcode = 'h8000;
      cmd(CMD_SWRST, 4'h0, 16'h0000);
      wait_init();
      cmp_all();
      end_of_test();
   end
endmodule
